// file: bit_skip_params.svh
// Constants for the bit, skip and branch execute block.
// Operation
// RQ1 - Bit clear writes zero to chosen bit.
// RQ2 - Bit set writes one to chosen bit.
// RQ3 - Bit test skips next when bit clear.
// RQ4 - Taken skip replaces fetched word with no-op.
// RQ5 - Decrement subtracts one, flags untouched.
// RQ6 - Destination bit picks working or file register.
// RQ7 - Zero decrement result skips next instruction.
// RQ8 - Branch loads eleven-bit immediate into counter.
// RQ9 - Upper counter bits come from page latch.
// RQ10 - Branch always takes two cycles.
// RQ11 - Increment wraps and updates zero flag.
// RQ12 - Other words pass through without side effects.
`ifndef BIT_SKIP_PARAMS_SVH
`define BIT_SKIP_PARAMS_SVH
`define INSTR_W      14
`define DATA_W       8
`define FADDR_W      7
`define PC_W         13
`define BRANCH_W     11
`define BITOP_CLR    4'h4
`define BITOP_SET    4'h5
`define BITOP_TEST   4'h6
`define BYTEOP_INC   6'h0A
`define BYTEOP_DEC   6'h0B
`define BRANCH_OP    3'h5
`define DEST_POS     7
`define BITSEL_LO    7
`define PAGE_HI      4
`define PAGE_LO      3
`endif

// file: bit_skip_pkg.sv
// Types shared by the bit, skip and branch execute block.
package bit_skip_pkg;
    typedef enum {
        OP_OTHER, OP_CLR, OP_SET, OP_TEST, OP_INC, OP_DEC, OP_BRANCH
    } op_t;
    typedef enum {
        EXEC_S, FLUSH_S
    } state_t;
endpackage

// file: instr_classify.sv
// Splits a 14-bit instruction word into operation and operand fields.
`timescale 1ns/100ps
`include "bit_skip_params.svh"
module instr_classify (
    input  wire logic [`INSTR_W-1:0]   instrWord,
    output bit_skip_pkg::op_t          opKind,
    output logic      [`FADDR_W-1:0]   fileSel,
    output logic      [2:0]            bitSel,
    output logic                       destFile,
    output logic      [`BRANCH_W-1:0]  branchTarget
);
    wire logic [3:0] bitOpField  = instrWord[13:10];
    wire logic [5:0] byteOpField = instrWord[13:8];
    wire logic [2:0] brOpField   = instrWord[13:11];

    assign fileSel      = instrWord[`FADDR_W-1:0];
    assign bitSel       = instrWord[`BITSEL_LO+2:`BITSEL_LO];
    assign destFile     = instrWord[`DEST_POS];
    assign branchTarget = instrWord[`BRANCH_W-1:0];

    // Unmatched words classify as other so the executer leaves them alone.
    assign opKind = (bitOpField == `BITOP_CLR)   ? bit_skip_pkg::OP_CLR    :
                    (bitOpField == `BITOP_SET)   ? bit_skip_pkg::OP_SET    :
                    (bitOpField == `BITOP_TEST)  ? bit_skip_pkg::OP_TEST   :
                    (byteOpField == `BYTEOP_INC) ? bit_skip_pkg::OP_INC    :
                    (byteOpField == `BYTEOP_DEC) ? bit_skip_pkg::OP_DEC    :
                    (brOpField == `BRANCH_OP)    ? bit_skip_pkg::OP_BRANCH :
                                                   bit_skip_pkg::OP_OTHER;
endmodule

// file: bit_skip_branch_exec.sv
// Executes bit clear, bit set, bit test, increment, decrement-skip and branch words.
`timescale 1ns/100ps
`include "bit_skip_params.svh"
module bit_skip_branch_exec (
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    input  wire logic                  instrValid,
    input  wire logic [`INSTR_W-1:0]   instrWord,
    input  wire logic [`DATA_W-1:0]    fileRdData,
    input  wire logic [`DATA_W-1:0]    pageLatch,
    output logic      [`FADDR_W-1:0]   fileAddr,
    output logic                       fileWrEn_q,
    output logic                       workWrEn_q,
    output logic      [`DATA_W-1:0]    resultData_q,
    output logic      [`FADDR_W-1:0]   resultAddr_q,
    output logic                       zeroWrEn_q,
    output logic                       zeroVal_q,
    output logic                       pcLoad_q,
    output logic      [`PC_W-1:0]      pcTarget_q,
    output logic                       discard_q,
    output logic                       passValid_q,
    output logic      [`INSTR_W-1:0]   passWord_q
);
    bit_skip_pkg::op_t    opKind;
    bit_skip_pkg::state_t state_q;
    bit_skip_pkg::state_t state_d;
    logic [`FADDR_W-1:0]  fileSel;
    logic [2:0]           bitSel;
    logic                 destFile;
    logic [`BRANCH_W-1:0] branchTarget;

    instr_classify u_classify (
        .instrWord    (instrWord),
        .opKind       (opKind),
        .fileSel      (fileSel),
        .bitSel       (bitSel),
        .destFile     (destFile),
        .branchTarget (branchTarget)
    );

    function automatic logic [`DATA_W-1:0] bitMask(input logic [2:0] sel);
        bitMask = `DATA_W'(1) << sel;
    endfunction

    assign fileAddr = fileSel;

    // A word fetched during a skip or branch is executed as a no-op.
    wire logic execNow  = instrValid && (state_q == bit_skip_pkg::EXEC_S);
    wire logic isClr    = execNow && (opKind == bit_skip_pkg::OP_CLR);
    wire logic isSet    = execNow && (opKind == bit_skip_pkg::OP_SET);
    wire logic isTest   = execNow && (opKind == bit_skip_pkg::OP_TEST);
    wire logic isInc    = execNow && (opKind == bit_skip_pkg::OP_INC);
    wire logic isDec    = execNow && (opKind == bit_skip_pkg::OP_DEC);
    wire logic isBranch = execNow && (opKind == bit_skip_pkg::OP_BRANCH);
    wire logic isOther  = execNow && (opKind == bit_skip_pkg::OP_OTHER);

    wire logic [`DATA_W-1:0] mask    = bitMask(bitSel);
    wire logic [`DATA_W-1:0] clrData = fileRdData & ~mask; // RQ1
    wire logic [`DATA_W-1:0] setData = fileRdData | mask; // RQ2
    wire logic [`DATA_W-1:0] incData = fileRdData + `DATA_W'(1); // RQ11
    wire logic [`DATA_W-1:0] decData = fileRdData - `DATA_W'(1); // RQ5
    wire logic testSkip = isTest && ((fileRdData & mask) == '0); // RQ3
    wire logic decSkip  = isDec && (decData == '0); // RQ7
    wire logic skipNext = testSkip || decSkip || isBranch; // RQ4 RQ10

    wire logic [`DATA_W-1:0] resultData_d =
        isClr ? clrData :
        isSet ? setData :
        isInc ? incData :
        isDec ? decData : resultData_q;
    wire logic fileWrEn_d = isClr || isSet || ((isInc || isDec) && destFile); // RQ6
    wire logic workWrEn_d = (isInc || isDec) && !destFile; // RQ6
    wire logic [`PC_W-1:0] pcTarget_d =
        {pageLatch[`PAGE_HI:`PAGE_LO], branchTarget}; // RQ8 RQ9

    always_comb begin
        case (state_q)
            bit_skip_pkg::EXEC_S: state_d = skipNext ? bit_skip_pkg::FLUSH_S
                                                     : bit_skip_pkg::EXEC_S;
            bit_skip_pkg::FLUSH_S: state_d = instrValid ? bit_skip_pkg::EXEC_S
                                                        : bit_skip_pkg::FLUSH_S;
            default: state_d = bit_skip_pkg::EXEC_S;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= bit_skip_pkg::EXEC_S;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fileWrEn_q   <= 1'b0;
            workWrEn_q   <= 1'b0;
            resultData_q <= 8'h00;
            resultAddr_q <= 7'h00;
        end else begin
            fileWrEn_q   <= fileWrEn_d;
            workWrEn_q   <= workWrEn_d;
            resultData_q <= resultData_d;
            resultAddr_q <= fileSel;
        end
    end

    // Only increment touches the zero flag; the rest leave status alone.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            zeroWrEn_q <= 1'b0;
            zeroVal_q  <= 1'b0;
        end else begin
            zeroWrEn_q <= isInc; // RQ11
            zeroVal_q  <= (incData == '0); // RQ11
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pcLoad_q   <= 1'b0;
            pcTarget_q <= 13'h0000;
            discard_q  <= 1'b0;
        end else begin
            pcLoad_q   <= isBranch; // RQ8
            pcTarget_q <= isBranch ? pcTarget_d : pcTarget_q; // RQ9
            discard_q  <= skipNext; // RQ4
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            passValid_q <= 1'b0;
            passWord_q  <= 14'h0000;
        end else begin
            passValid_q <= isOther; // RQ12
            passWord_q  <= isOther ? instrWord : passWord_q; // RQ12
        end
    end

    clr_write_a: assert property ( // RQ1
        @(posedge ref_clk) disable iff (!nrst)
        isClr |=> fileWrEn_q && !zeroWrEn_q
                  && resultData_q == ($past(fileRdData) & ~$past(mask)))
        else $error("Bit clear did not write the cleared bit.");

    set_write_a: assert property ( // RQ2
        @(posedge ref_clk) disable iff (!nrst)
        isSet |=> fileWrEn_q && !zeroWrEn_q
                  && resultData_q == ($past(fileRdData) | $past(mask)))
        else $error("Bit set did not write the set bit.");

    test_skip_a: assert property ( // RQ3
        @(posedge ref_clk) disable iff (!nrst)
        isTest |=> discard_q == (($past(fileRdData) & $past(mask)) == 8'h00)
                   && !fileWrEn_q && !workWrEn_q && !zeroWrEn_q)
        else $error("Bit test skip decision wrong.");

    skip_nop_a: assert property ( // RQ4
        @(posedge ref_clk) disable iff (!nrst)
        discard_q |-> state_q == bit_skip_pkg::FLUSH_S
                      ##1 (!fileWrEn_q && !workWrEn_q && !pcLoad_q && !passValid_q))
        else $error("Discarded word had an effect.");

    dec_value_a: assert property ( // RQ5
        @(posedge ref_clk) disable iff (!nrst)
        isDec |=> !zeroWrEn_q && resultData_q == $past(fileRdData) - 8'h01)
        else $error("Decrement result or flag wrong.");

    dest_select_a: assert property ( // RQ6
        @(posedge ref_clk) disable iff (!nrst)
        (isInc || isDec) |=> fileWrEn_q == $past(destFile)
                             && workWrEn_q == !$past(destFile))
        else $error("Destination select wrong.");

    dec_skip_a: assert property ( // RQ7
        @(posedge ref_clk) disable iff (!nrst)
        isDec |=> discard_q == ($past(fileRdData) == 8'h01))
        else $error("Decrement skip decision wrong.");

    branch_target_a: assert property ( // RQ8
        @(posedge ref_clk) disable iff (!nrst)
        isBranch |=> pcLoad_q && pcTarget_q[10:0] == $past(branchTarget))
        else $error("Branch low target bits wrong.");

    branch_page_a: assert property ( // RQ9
        @(posedge ref_clk) disable iff (!nrst)
        isBranch |=> pcTarget_q[12:11] == $past(pageLatch[4:3]))
        else $error("Branch page bits wrong.");

    branch_cycles_a: assert property ( // RQ10
        @(posedge ref_clk) disable iff (!nrst)
        isBranch |=> discard_q ##1 !pcLoad_q)
        else $error("Branch did not take two cycles.");

    inc_zero_a: assert property ( // RQ11
        @(posedge ref_clk) disable iff (!nrst)
        isInc |=> zeroWrEn_q && !discard_q
                  && zeroVal_q == ($past(fileRdData) == 8'hFF)
                  && resultData_q == $past(fileRdData) + 8'h01)
        else $error("Increment result or zero flag wrong.");

    other_pass_a: assert property ( // RQ12
        @(posedge ref_clk) disable iff (!nrst)
        isOther |=> passValid_q && passWord_q == $past(instrWord) && !fileWrEn_q
                    && !workWrEn_q && !zeroWrEn_q && !pcLoad_q && !discard_q)
        else $error("Other word was not passed cleanly.");

    // A discard that sees no word yet must wait, so the next word fetched is still dropped.
    flush_hold_a: assert property ( // RQ4
        @(posedge ref_clk) disable iff (!nrst)
        state_q == bit_skip_pkg::FLUSH_S && !instrValid |=> state_q == bit_skip_pkg::FLUSH_S)
        else $error("Discard state left before a word arrived.");

    flush_quiet_a: assert property ( // RQ4
        @(posedge ref_clk) disable iff (!nrst)
        state_q == bit_skip_pkg::FLUSH_S |=> !fileWrEn_q && !workWrEn_q && !zeroWrEn_q
                                             && !pcLoad_q && !discard_q && !passValid_q)
        else $error("Word in discard state had an effect.");

    zero_owner_a: assert property ( // RQ5
        @(posedge ref_clk) disable iff (!nrst)
        zeroWrEn_q |-> $past(opKind) == bit_skip_pkg::OP_INC)
        else $error("Zero flag touched by a word other than increment.");
endmodule

// file: reg_file_model.sv
// Behavioural data register file serving the execute block's reads and writes.
`timescale 1ns/100ps
`include "bit_skip_params.svh"
module reg_file_model (
    input  wire logic                  ref_clk,
    input  wire logic [`FADDR_W-1:0]   fileAddr,
    input  wire logic                  fileWrEn_q,
    input  wire logic [`FADDR_W-1:0]   resultAddr_q,
    input  wire logic [`DATA_W-1:0]    resultData_q,
    output logic      [`DATA_W-1:0]    fileRdData
);
    logic [`DATA_W-1:0] mem [0:127];
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i);
        end
        mem[127] = 8'hFF;
    end
    // Reads are combinational so the executing word sees its operand in the same cycle.
    assign fileRdData = mem[fileAddr];
    always @(posedge ref_clk) begin
        if (fileWrEn_q === 1'b1) begin
            mem[resultAddr_q] <= resultData_q;
        end
    end
endmodule

// file: bit_skip_branch_exec_tb.sv
// Self-checking random testbench for the bit, skip and branch execute block.
`timescale 1ns/100ps
`include "bit_skip_params.svh"
module bit_skip_branch_exec_tb;
    logic                 ref_clk = 1'b0;
    logic                 nrst = 1'b0;
    logic                 instrValid = 1'b0;
    logic [`INSTR_W-1:0]  instrWord = 14'h0000;
    logic [`DATA_W-1:0]   pageLatch = 8'h00;
    logic [`DATA_W-1:0]   fileRdData;
    logic [`FADDR_W-1:0]  fileAddr, resultAddr_q;
    logic                 fileWrEn_q, workWrEn_q, zeroWrEn_q, zeroVal_q;
    logic                 pcLoad_q, discard_q, passValid_q;
    logic [`DATA_W-1:0]   resultData_q;
    logic [`PC_W-1:0]     pcTarget_q;
    logic [`INSTR_W-1:0]  passWord_q;
    logic [5:0]           pulses;
    int                   n_errors = 0;
    int                   n_checks = 0;
    int                   seed = 74;
    logic [13:0]          w;

    always #5 ref_clk = ~ref_clk;
    assign pulses = {fileWrEn_q, workWrEn_q, zeroWrEn_q, pcLoad_q, discard_q, passValid_q};

    bit_skip_branch_exec bit_skip_branch_exec_inst (.ref_clk(ref_clk), .nrst(nrst),
        .instrValid(instrValid), .instrWord(instrWord), .fileRdData(fileRdData),
        .pageLatch(pageLatch), .fileAddr(fileAddr), .fileWrEn_q(fileWrEn_q),
        .workWrEn_q(workWrEn_q), .resultData_q(resultData_q), .resultAddr_q(resultAddr_q),
        .zeroWrEn_q(zeroWrEn_q), .zeroVal_q(zeroVal_q), .pcLoad_q(pcLoad_q),
        .pcTarget_q(pcTarget_q), .discard_q(discard_q), .passValid_q(passValid_q),
        .passWord_q(passWord_q));
    reg_file_model reg_file_model_inst (.ref_clk(ref_clk), .fileAddr(fileAddr),
        .fileWrEn_q(fileWrEn_q), .resultAddr_q(resultAddr_q), .resultData_q(resultData_q),
        .fileRdData(fileRdData));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Returns the expected pulses on top and the relevant data value below them.
    function automatic logic [21:0] predict(input logic [13:0] iw, input logic [7:0] d,
                                            input logic [7:0] pl);
        logic [7:0] m;
        m = 8'h01 << iw[9:7];
        if (iw[13:10] == 4'h4) return {6'b100000, 8'h00, d & ~m};
        if (iw[13:10] == 4'h5) return {6'b100000, 8'h00, d | m};
        if (iw[13:10] == 4'h6) return {4'b0000, ~|(d & m), 1'b0, 16'h0000};
        if (iw[13:8] == 6'h0A) return {iw[7], ~iw[7], 4'b1000, 7'h00, d == 8'hFF, d + 8'h01};
        if (iw[13:8] == 6'h0B) return {iw[7], ~iw[7], 2'b00, d == 8'h01, 1'b0, 8'h00, d - 8'h01};
        if (iw[13:11] == 3'h5) return {6'b000110, 3'h0, pl[4:3], iw[10:0]};
        return {6'b000001, 2'h0, iw};
    endfunction

    task automatic run(input logic [13:0] iw);
        logic [21:0] p;
        instrWord = iw;
        instrValid = 1'b1;
        pageLatch = 8'($random(seed));
        p = predict(iw, reg_file_model_inst.mem[iw[6:0]], pageLatch);
        @(posedge ref_clk);
        #1;
        chk(pulses, p[21:16]);
        chk(resultAddr_q, iw[6:0]);
        chk(fileAddr, iw[6:0]);
        if (p[21] | p[20]) chk(resultData_q, p[7:0]);
        if (p[19]) chk(zeroVal_q, p[8]);
        if (p[18]) chk(pcTarget_q, p[12:0]);
        if (p[16]) chk(passWord_q, p[13:0]);
        if (p[17]) begin
            instrWord = 14'($random(seed));
            if ($random(seed) % 3 == 0) begin
                instrValid = 1'b0;
                @(posedge ref_clk);
                #1;
                chk(pulses, 16'h0000);
                instrValid = 1'b1;
            end
            @(posedge ref_clk);
            #1;
            chk(pulses, 16'h0000);
        end
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        #1;
        chk(pulses, 16'h0000);
        nrst = 1'b1;
        @(posedge ref_clk);
        #1;
        run(14'h0B81);
        run(14'h0A7F);
        run(14'h2923);
        run(14'h1881);
        run(14'h0000);
        for (int i = 0; i < 700; i++) begin
            w = 14'($random(seed));
            case (i % 7)
                0: w[13:10] = 4'h4;
                1: w[13:10] = 4'h5;
                2: w[13:10] = 4'h6;
                3: w[13:8] = 6'h0A;
                4: w[13:8] = 6'h0B;
                5: w[13:11] = 3'h5;
                default: ;
            endcase
            if ($random(seed) % 5 == 0) begin
                instrValid = 1'b0;
                @(posedge ref_clk);
                #1;
                chk(pulses, 16'h0000);
            end
            run(w);
        end
        // A reset in the middle of a branch discard must clear it.
        instrWord = 14'h2800;
        instrValid = 1'b1;
        @(posedge ref_clk);
        #1;
        nrst = 1'b0;
        #1;
        chk(pulses, 16'h0000);
        instrValid = 1'b0;
        @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        @(posedge ref_clk);
        #1;
        run(14'h0000);
        results;
    end

    initial begin
        #1000000;
        n_errors++;
        results;
    end
endmodule
